// ---- verilog/irq_expander_consts.vh ----
`ifndef IRQ_EXPANDER_CONSTS_VH
`define IRQ_EXPANDER_CONSTS_VH
// Source counts and grouping
`define NUM_SRC        96
`define NUM_LINES      12
`define GRP_SIZE       8
`define SRC_W          7
`define GRP_W          4
// Vector fetch and register save time, CPU cycles
`define FETCH_CYCLES   3'h7
// Fixed sources inside the expander
`define SRC_EXT_ONE    3
`define SRC_EXT_TWO    4
`define SRC_TMR0       6
// Ack codes for the two direct lines
`define ACK_LINE13     4'hC
`define ACK_LINE14     4'hD
// Low-power modes
`define LPM_RUN        2'h0
`define LPM_IDLE       2'h1
`define LPM_STANDBY    2'h2
`define LPM_HALT       2'h3
// Register byte addresses
`define A_CTRL         12'h000
`define A_ENA0         12'h010
`define A_ENA1         12'h014
`define A_ENA2         12'h018
`define A_PEND0        12'h020
`define A_PEND1        12'h024
`define A_PEND2        12'h028
`define A_XCTRL        12'h030
`define A_XCNT1        12'h034
`define A_XCNT2        12'h038
`define A_XCNT13       12'h03C
`define A_STAT         12'h040
`define A_MASK         12'h044
`define A_STATE        12'h048
`define A_VEC_BASE     12'h400
`define A_VEC_LAST     12'h57C
// Field positions
`define CTRL_EN        0
`define CTRL_T1_13     1
`define XC_EN_LSB      0
`define XC_POL_LSB     8
`define ST_WAKE        4
`define ST_LOCKREF     5
`define ST_W           6
`endif

// ---- verilog/irq_expander.v ----
`timescale 1ns/10ps
`include "irq_expander_consts.vh"
// How it works
// RULE1 - Ninety-six request inputs; forty-five are wired to peripherals in this family.
// RULE2 - Requests form groups of eight; each group drives one of twelve CPU lines.
// RULE3 - One writable vector word per source, handed to the CPU when serviced.
// RULE4 - Vector fetch and register save take eight CPU clock cycles.
// RULE5 - Each source has its own enable; disabled sources never reach a line.
// RULE6 - Priority is fixed order in hardware plus software enable masking.
// RULE7 - Three maskable external inputs; the third shares a pin with the NMI.
// RULE8 - Every external input, NMI too, has edge polarity select and enable.
// RULE9 - Each maskable external input has a 16-bit up counter cleared on edges.
// RULE10 - Timer zero-reach requests feed the interrupt routing.
// RULE11 - Third timer goes straight to CPU line fourteen.
// RULE12 - Second timer may drive line thirteen; first timer is a grouped source.
// RULE13 - In idle, an enabled interrupt from a running peripheral wakes the CPU.
// RULE14 - In standby, an external edge wakes CPU and peripherals next cycle.
// RULE15 - In halt only reset or the NMI wakes the device.
// RULE16 - Enables, controls and vector table sit on the directly attached bus.
// RULE17 - Those registers take both 16-bit and 32-bit accesses.
// RULE18 - Protected areas ignore writes until unlocked; lock disables writes again.
// RULE19 - External pins are synchronised before edge detection; one request per edge.
module irq_expander (
  input  wire        mclk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg         pready_q,
  output reg  [31:0] prdata_q,
  output reg         pslverr_q,
  input  wire [95:0] periph_irq,
  input  wire [2:0]  timer_zero,
  input  wire        ext_irq_one_pin,
  input  wire        ext_irq_two_pin,
  input  wire        shared_nmi_irq_pin,
  input  wire        protected_write_unlock,
  input  wire        protected_write_lock,
  input  wire [1:0]  lpm_mode,
  input  wire        cpu_ack,
  input  wire [3:0]  cpu_ack_grp,
  output reg  [11:0] cpu_line_q,
  output reg         cpu_line_thirteen_q,
  output reg         cpu_line_fourteen_q,
  output reg         cpu_nmi_q,
  output reg         vec_valid_q,
  output reg  [31:0] vec_q,
  output reg  [6:0]  vec_src_q,
  output reg         wake_q,
  output reg         irq_q
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_FETCH = 1'b1;

  reg  [31:0] vec_ram [0:`NUM_SRC-1];
  reg  [95:0] req_prev_q;
  reg  [95:0] pend_q;
  reg  [95:0] en_q;
  reg  [1:0]  ctrl_q;
  reg  [11:0] xctrl_q;
  reg  [15:0] xcnt_q [0:2];
  reg  [`ST_W-1:0] stat_q;
  reg  [`ST_W-1:0] mask_q;
  reg         unlock_q;
  reg         state_q;
  reg  [2:0]  fcnt_q;
  reg  [6:0]  fsrc_q;
  reg  [2:0]  pin_s1_q;
  reg  [2:0]  pin_s2_q;
  reg  [2:0]  pin_s3_q;
  reg         line13_flag_q;
  reg         line14_flag_q;

  wire [95:0] src_in;
  wire [95:0] src_edge;
  wire [3:0]  x_edge;
  wire        wr_en;
  wire        rd_en;
  wire        vec_hit;
  wire [6:0]  vec_idx;
  wire [31:0] wmask;
  wire [95:0] live;

  // Timer zero and the first two external inputs enter fixed slots of the first group
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_SRC; gi = gi + 1) begin : g_src
      assign src_in[gi] = periph_irq[gi]                              // [RULE1]
        | ((gi == `SRC_TMR0) ? timer_zero[0] : 1'b0)                  // [RULE10] [RULE12]
        | ((gi == `SRC_EXT_ONE) ? x_edge[0] : 1'b0)
        | ((gi == `SRC_EXT_TWO) ? x_edge[1] : 1'b0);
      assign src_edge[gi] = src_in[gi] & ~req_prev_q[gi];
      assign live[gi]     = pend_q[gi] & en_q[gi];                    // [RULE5]
    end
  endgenerate

  // External pins: two-flop synchroniser, third flop for the edge
  always @(posedge mclk) begin
    if (rst) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_s3_q <= 3'h0;
    end else begin
      pin_s1_q <= {shared_nmi_irq_pin, ext_irq_two_pin, ext_irq_one_pin};
      pin_s2_q <= pin_s1_q;                                           // [RULE19]
      pin_s3_q <= pin_s2_q;
    end
  end

  // Channels 0..2 maskable, 3 is the NMI; 2 and 3 share the same pin
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ext
      localparam integer PIN = (gi == 3) ? 2 : gi;                    // [RULE7]
      wire rise = pin_s2_q[PIN] & ~pin_s3_q[PIN];
      wire fall = ~pin_s2_q[PIN] & pin_s3_q[PIN];
      // Polarity 1 picks the rising edge; enable gates the request
      assign x_edge[gi] = xctrl_q[`XC_EN_LSB + gi]                    // [RULE8] [RULE19]
        & (xctrl_q[`XC_POL_LSB + gi] ? rise : fall);
    end
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_cnt
      // Free-running stamp; a valid edge restarts it at zero
      always @(posedge mclk) begin
        if (rst) begin
          xcnt_q[gi] <= 16'h0000;
        end else if (x_edge[gi]) begin
          xcnt_q[gi] <= 16'h0000;                                     // [RULE9]
        end else begin
          xcnt_q[gi] <= xcnt_q[gi] + 16'h0001;
        end
      end
    end
  endgenerate

  // APB decode; no wait state, yet every answer comes from a flop set in the setup cycle
  assign rd_en   = psel & ~penable & ~pwrite;
  assign wr_en   = psel & penable & pwrite & pready_q;
  assign vec_hit = (paddr >= `A_VEC_BASE) && (paddr <= `A_VEC_LAST) && (paddr[1:0] == 2'h0);
  assign vec_idx = paddr[8:2] - 7'h00;
  // 16-bit halves are written independently; byte lanes pair into halves
  assign wmask   = {{16{pstrb[3] | pstrb[2]}}, {16{pstrb[1] | pstrb[0]}}};  // [RULE17]

  function mapped;
    input [11:0] a;
    begin
      case (a)
        `A_CTRL, `A_ENA0, `A_ENA1, `A_ENA2, `A_PEND0, `A_PEND1, `A_PEND2,
        `A_XCTRL, `A_XCNT1, `A_XCNT2, `A_XCNT13, `A_STAT, `A_MASK,
        `A_STATE: mapped = 1'b1;
        default:  mapped = 1'b0;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  // Read mux, registered in the setup cycle
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = 32'h0000_0000;
    if (vec_hit) begin
      rdata_d = vec_ram[vec_idx];
    end else begin
      case (paddr)
        `A_CTRL:   rdata_d = {30'h0, ctrl_q};
        `A_ENA0:   rdata_d = en_q[31:0];
        `A_ENA1:   rdata_d = en_q[63:32];
        `A_ENA2:   rdata_d = en_q[95:64];
        `A_PEND0:  rdata_d = pend_q[31:0];
        `A_PEND1:  rdata_d = pend_q[63:32];
        `A_PEND2:  rdata_d = pend_q[95:64];
        `A_XCTRL:  rdata_d = {20'h0, xctrl_q};
        `A_XCNT1:  rdata_d = {16'h0, xcnt_q[0]};
        `A_XCNT2:  rdata_d = {16'h0, xcnt_q[1]};
        `A_XCNT13: rdata_d = {16'h0, xcnt_q[2]};
        `A_STAT:   rdata_d = {26'h0, stat_q};
        `A_MASK:   rdata_d = {26'h0, mask_q};
        `A_STATE:  rdata_d = {26'h0, unlock_q, state_q, lpm_mode, line14_flag_q, line13_flag_q};
        default:   rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Bus answer flops
  always @(posedge mclk) begin
    if (rst) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~(vec_hit | mapped(paddr));
      if (rd_en) begin
        prdata_q <= rdata_d;
      end
    end
  end

  // Protected-write window for the vector table
  always @(posedge mclk) begin
    if (rst) begin
      unlock_q <= 1'b0;
    end else if (protected_write_lock) begin
      unlock_q <= 1'b0;                                               // [RULE18]
    end else if (protected_write_unlock) begin
      unlock_q <= 1'b1;                                               // [RULE18]
    end
  end

  // Vector RAM: no reset, software loads it after unlocking
  always @(posedge mclk) begin
    if (wr_en && vec_hit && unlock_q) begin
      vec_ram[vec_idx] <= merge(vec_ram[vec_idx], pwdata, wmask);     // [RULE3] [RULE16]
    end
  end

  // Merged write values, cut to each register's width below; bits above that width are dropped
  wire [31:0] ctrl_wr  = merge({30'h0, ctrl_q}, pwdata, wmask);
  wire [31:0] xctrl_wr = merge({20'h0, xctrl_q}, pwdata, wmask);
  wire [31:0] mask_wr  = merge({26'h0, mask_q}, pwdata, wmask);

  // Control, enable and mask registers
  always @(posedge mclk) begin
    if (rst) begin
      ctrl_q  <= 2'h0;
      en_q    <= 96'h0;
      xctrl_q <= 12'h000;
      mask_q  <= {`ST_W{1'b0}};
    end else if (wr_en) begin
      case (paddr)
        `A_CTRL:  ctrl_q  <= ctrl_wr[1:0];
        `A_ENA0:  en_q[31:0]  <= merge(en_q[31:0], pwdata, wmask);    // [RULE5] [RULE16]
        `A_ENA1:  en_q[63:32] <= merge(en_q[63:32], pwdata, wmask);
        `A_ENA2:  en_q[95:64] <= merge(en_q[95:64], pwdata, wmask);
        `A_XCTRL: xctrl_q <= xctrl_wr[11:0] & 12'hF0F;               // [RULE8]
        `A_MASK:  mask_q  <= mask_wr[`ST_W-1:0];
        default:  ctrl_q  <= ctrl_q;
      endcase
    end
  end

  // Fixed-order pick inside the acknowledged group: lowest index wins
  reg [2:0] pick_d;
  reg       found_d;
  integer   k;
  integer   j;
  always @* begin
    pick_d  = 3'h0;
    found_d = 1'b0;
    for (k = `GRP_SIZE - 1; k >= 0; k = k - 1) begin
      if (cpu_ack_grp < `NUM_LINES && live[{cpu_ack_grp[3:0], 3'h0} + k]) begin
        pick_d  = k[2:0];                                             // [RULE6]
        found_d = 1'b1;
      end
    end
  end

  wire       take   = cpu_ack && (state_q == ST_IDLE) && found_d;
  wire [6:0] take_i = {cpu_ack_grp[3:0], pick_d};

  // Pending flags: an edge in the clear cycle wins over the clear
  always @(posedge mclk) begin
    if (rst) begin
      req_prev_q <= 96'h0;
      pend_q     <= 96'h0;
    end else begin
      req_prev_q <= src_in;
      for (j = 0; j < `NUM_SRC; j = j + 1) begin
        if (src_edge[j]) begin
          pend_q[j] <= 1'b1;
        end else if (take && take_i == j) begin
          pend_q[j] <= 1'b0;
        end else if (wr_en && paddr == (`A_PEND0 + 12'h004 * (j / 32))
                     && pwdata[j % 32] && wmask[j % 32]) begin
          pend_q[j] <= 1'b0;
        end
      end
    end
  end

  // Vector fetch: eight cycles from ack to the vector word
  always @(posedge mclk) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      fcnt_q      <= 3'h0;
      fsrc_q      <= 7'h00;
      vec_valid_q <= 1'b0;
      vec_q       <= 32'h0000_0000;
      vec_src_q   <= 7'h00;
    end else begin
      vec_valid_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            state_q <= ST_FETCH;
            fcnt_q  <= 3'h0;
            fsrc_q  <= take_i;
          end
        end
        ST_FETCH: begin
          fcnt_q <= fcnt_q + 3'h1;
          if (fcnt_q == `FETCH_CYCLES - 3'h1) begin
            state_q     <= ST_IDLE;                                   // [RULE4]
            vec_valid_q <= 1'b1;                                      // [RULE3] [RULE4]
            vec_q       <= vec_ram[fsrc_q];
            vec_src_q   <= fsrc_q;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Group lines and the two direct lines
  reg [11:0] grp_d;
  integer    g;
  always @* begin
    grp_d = 12'h000;
    for (g = 0; g < `NUM_LINES; g = g + 1) begin
      grp_d[g] = ctrl_q[`CTRL_EN] & (|live[g*`GRP_SIZE +: `GRP_SIZE]);  // [RULE2] [RULE5]
    end
  end

  wire set13 = x_edge[2] | (ctrl_q[`CTRL_T1_13] & timer_zero[1]);     // [RULE12]
  wire ack13 = cpu_ack && cpu_ack_grp == `ACK_LINE13;
  wire ack14 = cpu_ack && cpu_ack_grp == `ACK_LINE14;

  always @(posedge mclk) begin
    if (rst) begin
      cpu_line_q          <= 12'h000;
      line13_flag_q       <= 1'b0;
      line14_flag_q       <= 1'b0;
      cpu_line_thirteen_q <= 1'b0;
      cpu_line_fourteen_q <= 1'b0;
      cpu_nmi_q           <= 1'b0;
    end else begin
      cpu_line_q    <= grp_d;                                         // [RULE2]
      line13_flag_q <= set13 | (line13_flag_q & ~ack13);
      line14_flag_q <= timer_zero[2] | (line14_flag_q & ~ack14);      // [RULE11]
      cpu_line_thirteen_q <= set13 | (line13_flag_q & ~ack13);
      cpu_line_fourteen_q <= timer_zero[2] | (line14_flag_q & ~ack14);
      cpu_nmi_q           <= x_edge[3];                               // [RULE8]
    end
  end

  // Wake logic per low-power mode
  reg wake_d;
  always @* begin
    case (lpm_mode)
      `LPM_IDLE:    wake_d = |grp_d | set13 | timer_zero[2] | x_edge[3];  // [RULE13]
      `LPM_STANDBY: wake_d = |x_edge;                                 // [RULE14]
      `LPM_HALT:    wake_d = x_edge[3];                               // [RULE15]
      default:      wake_d = 1'b0;
    endcase
  end

  // Sticky status, write one to clear, set beats clear
  wire [`ST_W-1:0] st_set = {wr_en & vec_hit & ~unlock_q, wake_d, x_edge};
  wire [`ST_W-1:0] st_clr = (wr_en && paddr == `A_STAT) ? (pwdata[`ST_W-1:0]
                            & wmask[`ST_W-1:0]) : {`ST_W{1'b0}};
  always @(posedge mclk) begin
    if (rst) begin
      stat_q <= {`ST_W{1'b0}};
      wake_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= st_set | (stat_q & ~st_clr);
      wake_q <= wake_d;                                               // [RULE14]
      irq_q  <= |((st_set | (stat_q & ~st_clr)) & mask_q);
    end
  end

endmodule

// ---- testbench/irq_expander_assertions.sv ----
`timescale 1ns/10ps
`include "irq_expander_consts.vh"
module irq_expander_checker (
  input wire        mclk,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire [2:0]  timer_zero,
  input wire [1:0]  lpm_mode,
  input wire        cpu_ack,
  input wire        pready_q,
  input wire        pslverr_q,
  input wire [11:0] cpu_line_q,
  input wire        cpu_line_fourteen_q,
  input wire        cpu_nmi_q,
  input wire        vec_valid_q,
  input wire [31:0] vec_q,
  input wire        wake_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Bus answers exactly once, right after setup
  chk_apb_answer: assert property (psel && !penable |=> pready_q)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready_q |=> !pready_q)
    else $error("ready held too long");
  chk_err_ready: assert property (pslverr_q |-> pready_q)
    else $error("error without ready");
  // Vector arrives eight cycles after the taken acknowledge
  chk_fetch_eight: assert property (vec_valid_q |-> $past(cpu_ack, 8))
    else $error("vector not eight cycles after ack");
  chk_vec_hold: assert property (!vec_valid_q |-> $stable(vec_q))
    else $error("vector changed without fetch");
  // Wake only where the mode allows it
  chk_run_quiet: assert property (wake_q |-> $past(lpm_mode) != `LPM_RUN)
    else $error("wake in run mode");
  chk_idle_wake: assert property (lpm_mode == `LPM_IDLE && (|cpu_line_q) && $stable(lpm_mode)
    |-> ##[0:2] wake_q)
    else $error("no wake from idle");
  chk_nmi_pulse: assert property (cpu_nmi_q |=> !cpu_nmi_q)
    else $error("nmi pulse too long");
  chk_line14_set: assert property ($rose(timer_zero[2]) |-> ##[1:3] cpu_line_fourteen_q)
    else $error("timer two missed line fourteen");
endmodule
bind irq_expander irq_expander_checker irq_expander_checker_inst (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .timer_zero(timer_zero),
  .lpm_mode(lpm_mode), .cpu_ack(cpu_ack), .pready_q(pready_q), .pslverr_q(pslverr_q),
  .cpu_line_q(cpu_line_q), .cpu_line_fourteen_q(cpu_line_fourteen_q), .cpu_nmi_q(cpu_nmi_q),
  .vec_valid_q(vec_valid_q), .vec_q(vec_q), .wake_q(wake_q));

// ---- testbench/cpu_model.sv ----
`timescale 1ns/10ps
module cpu_model (
  input  wire        mclk,
  input  wire        rst,
  input  wire        ack_en,
  input  wire [11:0] cpu_line_q,
  input  wire        cpu_line_thirteen_q,
  input  wire        cpu_line_fourteen_q,
  input  wire        vec_valid_q,
  output reg         cpu_ack,
  output reg  [3:0]  cpu_ack_grp
);
  reg     busy_q;
  integer g;
  // Acks one line at a time; a fetch in flight blocks new acks
  always @(posedge mclk) begin
    cpu_ack <= 1'b0;
    if (rst) begin
      busy_q      <= 1'b0;
      cpu_ack_grp <= 4'h0;
    end else if (vec_valid_q) begin
      busy_q <= 1'b0;
    end else if (ack_en && !busy_q && !cpu_ack) begin
      if (cpu_line_fourteen_q) begin
        cpu_ack     <= 1'b1;
        cpu_ack_grp <= 4'hD;
      end else if (cpu_line_thirteen_q) begin
        cpu_ack     <= 1'b1;
        cpu_ack_grp <= 4'hC;
      end else begin
        // Descending loop leaves the lowest live group chosen
        for (g = 11; g >= 0; g = g - 1) begin
          if (cpu_line_q[g]) begin
            cpu_ack     <= 1'b1;
            cpu_ack_grp <= g[3:0];
            busy_q      <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ---- testbench/irq_expander_test.sv ----
`timescale 1ns/10ps
`include "irq_expander_consts.vh"
module irq_expander_test;
  reg         mclk, rst, psel, penable, pwrite, p1, p2, p3, unl, lck, ack_en;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rdata, c1;
  reg  [3:0]  pstrb;
  reg  [95:0] periph_irq;
  reg  [2:0]  timer_zero;
  reg  [1:0]  lpm_mode;
  reg         rerr;
  wire        pready_q, pslverr_q, cpu_ack, lt_q, lf_q, nmi_q, vv_q, wake_q, irq_q;
  wire [31:0] prdata_q, vec_q;
  wire [11:0] cpu_line_q;
  wire [6:0]  vec_src_q;
  wire [3:0]  cpu_ack_grp;
  integer     n_errors, tests_run, n_nmi;
  irq_expander irq_expander_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready_q(pready_q),
    .prdata_q(prdata_q), .pslverr_q(pslverr_q), .periph_irq(periph_irq), .timer_zero(timer_zero),
    .ext_irq_one_pin(p1), .ext_irq_two_pin(p2), .shared_nmi_irq_pin(p3),
    .protected_write_unlock(unl), .protected_write_lock(lck), .lpm_mode(lpm_mode),
    .cpu_ack(cpu_ack), .cpu_ack_grp(cpu_ack_grp), .cpu_line_q(cpu_line_q),
    .cpu_line_thirteen_q(lt_q), .cpu_line_fourteen_q(lf_q), .cpu_nmi_q(nmi_q),
    .vec_valid_q(vv_q), .vec_q(vec_q), .vec_src_q(vec_src_q), .wake_q(wake_q), .irq_q(irq_q));
  cpu_model cpu_model_inst (.mclk(mclk), .rst(rst), .ack_en(ack_en), .cpu_line_q(cpu_line_q),
    .cpu_line_thirteen_q(lt_q), .cpu_line_fourteen_q(lf_q), .vec_valid_q(vv_q),
    .cpu_ack(cpu_ack), .cpu_ack_grp(cpu_ack_grp));
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  // Counts NMI pulses; a held pin must not give a second one
  always @(posedge mclk) begin
    if (nmi_q === 1'b1) n_nmi <= n_nmi + 1;
  end
  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // One transfer, then an idle edge so psel is never assigned twice in a step
  task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
    integer k;
    begin
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      @(posedge mclk);
      while (pready_q !== 1'b1) begin
        k = k + 1;
        if (k > 20) begin n_errors = n_errors + 1; finish_test; end
        @(posedge mclk);
      end
      rdata = prdata_q; rerr = pslverr_q;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d); apb(1'b1, a, d, 4'hF); endtask
  task rd(input [11:0] a, input [31:0] e); begin apb(1'b0, a, 32'h0, 4'hF); check(rdata, e); end
  endtask
  task see_wake(input e);
    integer k;
    reg     s;
    begin
      s = 1'b0;
      for (k = 0; k < 12; k = k + 1) begin @(posedge mclk); if (wake_q === 1'b1) s = 1'b1; end
      check(s, e);
    end
  endtask
  task wait_vec;
    integer k;
    begin
      k = 0;
      @(posedge mclk);
      while (vv_q !== 1'b1) begin
        k = k + 1;
        if (k > 40) begin n_errors = n_errors + 1; finish_test; end
        @(posedge mclk);
      end
    end
  endtask
  // Main sequence
  initial begin
    n_errors = 0; tests_run = 0; n_nmi = 0; mclk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0; periph_irq = 96'h0; timer_zero = 3'h0;
    p1 = 0; p2 = 0; p3 = 0; unl = 0; lck = 0; ack_en = 0; lpm_mode = `LPM_RUN;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check({cpu_line_q, irq_q, wake_q, vv_q}, 32'h0);
    wr(`A_CTRL, 32'h1); rd(`A_CTRL, 32'h1);
    apb(1'b0, 12'h100, 32'h0, 4'hF); check(rerr, 1'b1);
    apb(1'b1, `A_ENA1, 32'hFFFF_FFFF, 4'h3); rd(`A_ENA1, 32'h0000_FFFF);
    apb(1'b1, `A_ENA1, 32'h1234_0000, 4'hC); rd(`A_ENA1, 32'h1234_FFFF);
    wr(`A_ENA1, 32'h0);
    $display("test registers done");
    unl <= 1'b1; @(posedge mclk); unl <= 1'b0;
    wr(12'h404, 32'hA0A0_0001); wr(12'h418, 32'hA0A0_0006); wr(12'h424, 32'hA0A0_0009);
    lck <= 1'b1; @(posedge mclk); lck <= 1'b0;
    wr(12'h404, 32'h5555_5555); rd(12'h404, 32'hA0A0_0001);
    apb(1'b0, `A_STAT, 32'h0, 4'hF); check(rdata & 32'h20, 32'h20);
    wr(`A_STAT, 32'h3F);
    $display("test lock done");
    wr(`A_ENA0, 32'h0000_0242);
    periph_irq <= 96'h4; @(posedge mclk); periph_irq <= 96'h0;
    repeat (4) @(posedge mclk);
    check(cpu_line_q, 12'h000);
    periph_irq <= 96'h202; timer_zero <= 3'h1; @(posedge mclk);
    periph_irq <= 96'h0; timer_zero <= 3'h4; @(posedge mclk); timer_zero <= 3'h0;
    repeat (4) @(posedge mclk);
    check(cpu_line_q, 12'h003);
    check(lf_q, 1'b1);
    rd(`A_PEND0, 32'h0000_0246);
    $display("test grouping done");
    wr(`A_XCTRL, 32'h0000_0909);
    lpm_mode <= `LPM_HALT; see_wake(1'b0);
    p1 <= 1'b1; see_wake(1'b0);
    p3 <= 1'b1; see_wake(1'b1);
    lpm_mode <= `LPM_STANDBY; p1 <= 1'b0; see_wake(1'b0);
    p1 <= 1'b1; see_wake(1'b1);
    lpm_mode <= `LPM_IDLE; see_wake(1'b1);
    lpm_mode <= `LPM_RUN; repeat (2) @(posedge mclk); see_wake(1'b0);
    $display("test wake done");
    p1 <= 1'b0; repeat (6) @(posedge mclk);
    wr(`A_STAT, 32'h3F);
    p1 <= 1'b1; repeat (6) @(posedge mclk);
    check(irq_q, 1'b0);
    apb(1'b0, `A_STAT, 32'h0, 4'hF); check(rdata & 32'h1, 32'h1);
    wr(`A_MASK, 32'h1); @(posedge mclk); check(irq_q, 1'b1);
    apb(1'b0, `A_XCNT1, 32'h0, 4'hF); c1 = rdata;
    apb(1'b0, `A_XCNT1, 32'h0, 4'hF); check(rdata - c1, 32'h3);
    wr(`A_STAT, 32'h1); @(posedge mclk); check(irq_q, 1'b0);
    p1 <= 1'b0; repeat (6) @(posedge mclk);
    apb(1'b0, `A_STAT, 32'h0, 4'hF); check(rdata & 32'h1, 32'h0);
    $display("test external done");
    wr(`A_CTRL, 32'h3);
    timer_zero <= 3'h2;
    @(posedge mclk);
    timer_zero <= 3'h0;
    repeat (2) @(posedge mclk);
    check(lt_q, 1'b1);
    check(n_nmi, 32'h1);
    ack_en <= 1'b1;
    wait_vec; check(vec_src_q, 7'h01); check(vec_q, 32'hA0A0_0001);
    wait_vec; check(vec_src_q, 7'h06); check(vec_q, 32'hA0A0_0006);
    wait_vec; check(vec_src_q, 7'h09); check(vec_q, 32'hA0A0_0009);
    repeat (3) @(posedge mclk);
    check(cpu_line_q, 12'h000);
    check(lf_q, 1'b0);
    check(lt_q, 1'b0);
    $display("test service done");
    finish_test;
  end
endmodule
